// file: rtl/lcdc_decoder.sv
// Serial command decoder, display RAM and time base/watchdog for the LCD driver.
//
// Our own choices: the placing of the registers and the packed cfg output port.
`timescale 1ns/1ps
`default_nettype none

module lcdc_decoder #(
  parameter int unsigned TICK_CYCLES = lcdc_pkg::TB_STEP_CYCLES,
  parameter int unsigned RAM_DEPTH = lcdc_pkg::RAM_DEPTH
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe_n,
  output logic irq_n,
  output logic irq_oe_n,
  output lcdc_pkg::lcdc_cfg_type cfg
);

  localparam int RAM_AW = $clog2(RAM_DEPTH);
  localparam int PW = $clog2(TICK_CYCLES);

  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [3:0] pin_st;
  logic [3:0] pin_prev;
  logic cs_active;
  logic wr_rise;
  logic rd_fall;
  logic din;
  lcdc_pkg::lcdc_state_type state;
  logic is_read;
  logic [3:0] bit_cnt;
  logic [8:0] shift;
  logic [5:0] addr;
  logic [1:0] wr_idx;
  logic [1:0] rd_idx;
  logic [3:0] wr_nib;
  logic [3:0] next_nib;
  logic [RAM_AW-1:0] waddr;
  logic wr_commit;
  logic rd_bit;
  logic [3:0] mem [RAM_DEPTH];
  logic cmd_fire;
  logic [8:0] cmd_word;
  logic [3:0] cmd_hi;
  logic [3:0] cmd_lo;
  logic cmd_known;
  logic tb_clear;
  logic wdt_clear;
  lcdc_pkg::lcdc_cfg_type next_cfg;
  logic [PW-1:0] presc;
  logic [7:0] tb_count;
  logic [7:0] rate_mask;
  logic tb_run;
  logic tick;
  logic sel_event;
  logic tb_level;
  logic [1:0] wdt_cnt;
  logic wdt_flag;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Pins are sampled three deep; a level counts only once two stages agree.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1 <= lcdc_pkg::PIN_IDLE;
      pin_s2 <= lcdc_pkg::PIN_IDLE;
      pin_s3 <= lcdc_pkg::PIN_IDLE;
      pin_st <= lcdc_pkg::PIN_IDLE;
      pin_prev <= lcdc_pkg::PIN_IDLE;
    end
    else
    begin
      pin_s1 <= {data_in, rd_n, wr_n, cs_n};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_st <= (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin_st & (pin_s2 ^ pin_s3));
      pin_prev <= pin_st;
    end
  end

  assign cs_active = ~pin_st[0];
  assign wr_rise = pin_st[1] & ~pin_prev[1];
  assign rd_fall = ~pin_st[2] & pin_prev[2];
  assign din = pin_st[3];

  assign waddr = addr[RAM_AW-1:0];
  assign next_nib = {din, wr_nib[2:0]};
  assign rd_bit = mem[waddr][rd_idx];
  assign wr_commit = cs_active && wr_rise && state == lcdc_pkg::ST_DATA && !is_read
    && wr_idx == lcdc_pkg::NIB_LAST;

  // Serial framing: identifier, address, data nibbles or nine-bit commands.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= lcdc_pkg::ST_ID;
      is_read <= 1'h0;
      bit_cnt <= 4'h0;
      shift <= 9'h000;
      addr <= 6'h00;
      wr_idx <= 2'h0;
      rd_idx <= 2'h0;
      wr_nib <= 4'h0;
      cmd_fire <= 1'h0;
      cmd_word <= 9'h000;
    end
    else
    begin
      cmd_fire <= 1'h0;
      if (!cs_active)
      begin
        state <= lcdc_pkg::ST_ID;
        bit_cnt <= 4'h0;
        wr_idx <= 2'h0;
        rd_idx <= 2'h0;
      end
      else if (wr_rise)
      begin
        shift <= {shift[7:0], din};
        case (state)
          lcdc_pkg::ST_ID:
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == lcdc_pkg::ID_LAST)
            begin
              bit_cnt <= 4'h0;
              case ({shift[1:0], din})
                lcdc_pkg::ID_READ:
                begin
                  state <= lcdc_pkg::ST_ADDR;
                  is_read <= 1'h1;
                end
                lcdc_pkg::ID_WRITE:
                begin
                  state <= lcdc_pkg::ST_ADDR;
                  is_read <= 1'h0;
                end
                lcdc_pkg::ID_CMD:
                begin
                  state <= lcdc_pkg::ST_CMD;
                end
                default:
                begin
                  state <= lcdc_pkg::ST_ID;
                end
              endcase
            end
          end
          lcdc_pkg::ST_ADDR:
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == lcdc_pkg::ADDR_LAST)
            begin
              bit_cnt <= 4'h0;
              addr <= {shift[4:0], din};
              state <= lcdc_pkg::ST_DATA;
              wr_idx <= 2'h0;
              rd_idx <= 2'h0;
            end
          end
          lcdc_pkg::ST_DATA:
          begin
            if (!is_read)
            begin
              wr_nib[wr_idx] <= din;
              wr_idx <= wr_idx + 2'h1;
              if (wr_idx == lcdc_pkg::NIB_LAST)
              begin
                addr <= addr + 6'h01;
                rd_idx <= 2'h0;
              end
            end
          end
          lcdc_pkg::ST_CMD:
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == lcdc_pkg::CMD_LAST)
            begin
              bit_cnt <= 4'h0;
              cmd_word <= {shift[7:0], din};
              cmd_fire <= 1'h1;
            end
          end
          default:
          begin
            state <= lcdc_pkg::ST_ID;
          end
        endcase
      end
      else if (rd_fall && state == lcdc_pkg::ST_DATA)
      begin
        rd_idx <= rd_idx + 2'h1;
        // A read-modify-write keeps the address so the following write lands on it.
        if (rd_idx == lcdc_pkg::NIB_LAST && is_read)
        begin
          addr <= addr + 6'h01;
        end
      end
    end
  end

  // The address top bit is ignored when the memory holds fewer than 64 nibbles.
  always_ff @(posedge clk)
  begin
    if (wr_commit)
    begin
      mem[waddr] <= next_nib;
    end
  end

  // Read bits leave on the read clock's falling edge and stay driven until a write-clock rise or deselect.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      data_out <= 1'h0;
      data_oe_n <= 1'h1;
    end
    else if (!cs_active || state != lcdc_pkg::ST_DATA)
    begin
      data_oe_n <= 1'h1;
    end
    else if (rd_fall)
    begin
      data_out <= rd_bit;
      data_oe_n <= 1'h0;
    end
    else if (wr_rise)
    begin
      data_oe_n <= 1'h1;
    end
  end

  assign cmd_hi = cmd_word[8:5];
  assign cmd_lo = cmd_word[4:1];

  // Command decode; the trailing bit and marked fields are never looked at.
  always_comb
  begin
    next_cfg = cfg;
    tb_clear = 1'h0;
    wdt_clear = 1'h0;
    cmd_known = 1'h1;
    case (cmd_hi)
      lcdc_pkg::GRP_SYS:
      begin
        case (cmd_lo)
          lcdc_pkg::SYSTEM_DISABLE_CMD:
          begin
            next_cfg.osc_on = 1'h0;
            next_cfg.bias_on = 1'h0;
          end
          lcdc_pkg::SYSTEM_ENABLE_CMD: next_cfg.osc_on = 1'h1;
          lcdc_pkg::LCD_OFF: next_cfg.bias_on = 1'h0;
          lcdc_pkg::LCD_ON: next_cfg.bias_on = 1'h1;
          lcdc_pkg::TB_DIS: next_cfg.tb_out_en = 1'h0;
          lcdc_pkg::WATCHDOG_OUTPUT_DISABLE_CMD: next_cfg.wdt_out_en = 1'h0;
          lcdc_pkg::TB_EN:
          begin
            next_cfg.tb_out_en = 1'h1;
            next_cfg.tb_route = 1'h1;
          end
          lcdc_pkg::WATCHDOG_OUTPUT_ENABLE_CMD:
          begin
            next_cfg.wdt_out_en = 1'h1;
            next_cfg.tb_route = 1'h0;
          end
          lcdc_pkg::TONE_OFF: next_cfg.buzzer_on = 1'h0;
          lcdc_pkg::TONE_ON: next_cfg.buzzer_on = 1'h1;
          default:
          begin
            if (cmd_lo[3:2] == lcdc_pkg::CLEAR_PAIR)
            begin
              tb_clear = 1'h1;
              wdt_clear = cmd_lo[1];
            end
            else
            begin
              cmd_known = 1'h0;
            end
          end
        endcase
      end
      lcdc_pkg::GRP_SRC:
      begin
        if (cmd_lo[3:2] == lcdc_pkg::SRC_NONE)
        begin
          cmd_known = 1'h0;
        end
        else
        begin
          next_cfg.clk_src = cmd_lo[3:2];
        end
      end
      lcdc_pkg::GRP_BIAS:
      begin
        if (cmd_lo[3:2] == lcdc_pkg::COMMONS_BAD)
        begin
          cmd_known = 1'h0;
        end
        else
        begin
          next_cfg.commons = cmd_lo[3:2];
          next_cfg.third_bias = cmd_lo[0];
        end
      end
      lcdc_pkg::GRP_MODE:
      begin
        if (cmd_lo == lcdc_pkg::MODE_TEST)
        begin
          next_cfg.test_mode = 1'h1;
        end
        else if (cmd_lo == lcdc_pkg::MODE_NORMAL)
        begin
          next_cfg.test_mode = 1'h0;
        end
        else
        begin
          cmd_known = 1'h0;
        end
      end
      default:
      begin
        case (cmd_hi[3:1])
          lcdc_pkg::U3_HIGH: next_cfg.buzzer_low = 1'h0;
          lcdc_pkg::U3_LOW: next_cfg.buzzer_low = 1'h1;
          lcdc_pkg::U3_IRQ: next_cfg.irq_en = cmd_lo[3];
          lcdc_pkg::U3_RATE: next_cfg.rate = cmd_lo[2:0];
          default: cmd_known = 1'h0;
        endcase
      end
    endcase
    if (!cmd_fire || !cmd_known)
    begin
      next_cfg = cfg;
      tb_clear = 1'h0;
      wdt_clear = 1'h0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg <= lcdc_pkg::CFG_RESET;
    end
    else
    begin
      cfg <= next_cfg;
    end
  end

  // An external source keeps the time base alive even with the oscillator stopped.
  assign tb_run = cfg.osc_on | (cfg.clk_src == lcdc_pkg::SRC_EXT);
  assign tick = tb_run && presc == PW'(TICK_CYCLES - 1);
  assign rate_mask = 8'hFF >> cfg.rate;
  assign sel_event = tick && ((tb_count & rate_mask) == rate_mask);
  assign tb_level = tb_count[3'h7 - cfg.rate];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      presc <= '0;
      tb_count <= 8'h00;
    end
    else if (tb_clear)
    begin
      presc <= '0;
      tb_count <= 8'h00;
    end
    else if (tb_run)
    begin
      presc <= tick ? '0 : presc + PW'(1);
      if (tick)
      begin
        tb_count <= tb_count + 8'h01;
      end
    end
  end

  // A time-out in the same cycle as a clear still sets the flag.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wdt_cnt <= 2'h0;
      wdt_flag <= 1'h0;
    end
    else
    begin
      if (wdt_clear)
      begin
        wdt_cnt <= 2'h0;
      end
      else if (sel_event)
      begin
        wdt_cnt <= wdt_cnt + 2'h1;
      end
      wdt_flag <= (wdt_flag & ~wdt_clear) | (sel_event & wdt_cnt == lcdc_pkg::WDT_LAST);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_n <= 1'h1;
      irq_oe_n <= 1'h1;
    end
    else
    begin
      irq_oe_n <= ~cfg.irq_en;
      if (cfg.tb_route)
      begin
        irq_n <= cfg.tb_out_en ? tb_level : 1'h1;
      end
      else
      begin
        irq_n <= ~(cfg.wdt_out_en & wdt_flag);
      end
    end
  end

  sequence s_cmd(logic [3:0] hi, logic [3:0] lo);
    cmd_fire && cmd_hi == hi && cmd_lo == lo;
  endsequence

  sequence s_read_edge;
    cs_active && rd_fall && state == lcdc_pkg::ST_DATA;
  endsequence

  a_sys_disable: assert property (s_cmd(lcdc_pkg::GRP_SYS, lcdc_pkg::SYSTEM_DISABLE_CMD)
    |=> !cfg.osc_on && !cfg.bias_on)
    else $error("System disable left oscillator or bias running.");

  a_sys_enable: assert property (s_cmd(lcdc_pkg::GRP_SYS, lcdc_pkg::SYSTEM_ENABLE_CMD)
    |=> cfg.osc_on && cfg.bias_on == $past(cfg.bias_on))
    else $error("System enable did not start oscillator alone.");

  a_bias_on: assert property (s_cmd(lcdc_pkg::GRP_SYS, lcdc_pkg::LCD_ON)
    |=> cfg.bias_on)
    else $error("Bias generator not enabled.");

  a_tb_clear: assert property (cmd_fire && cmd_hi == lcdc_pkg::GRP_SYS
    && cmd_lo[3:2] == lcdc_pkg::CLEAR_PAIR |=> tb_count == 8'h00 ##1 tb_count <= 8'h01)
    else $error("Time base counter not cleared.");

  a_wdt_clear: assert property (s_cmd(lcdc_pkg::GRP_SYS, 4'hE)
    |=> wdt_cnt == 2'h0 && tb_count == 8'h00)
    else $error("Watchdog clear left a stage running.");

  a_wdt_timeout: assert property (sel_event && wdt_cnt == 2'h3 |=> wdt_flag)
    else $error("Watchdog flag missing after fourth period.");

  a_cs_mode_reset: assert property (!cs_active |=> state == lcdc_pkg::ST_ID
    && bit_cnt == 4'h0)
    else $error("Deselect did not reset the mode.");

  a_cmd_repeat: assert property (cmd_fire |-> state == lcdc_pkg::ST_CMD
    && bit_cnt == 4'h0)
    else $error("Command mode not kept after a command.");

  a_read_order: assert property (s_read_edge |=> !data_oe_n
    && data_out == $past(rd_bit))
    else $error("Read bit not driven from addressed nibble.");

  a_rmw_same_addr: assert property (s_read_edge and !is_read |=> addr == $past(addr))
    else $error("Read-modify-write moved the address early.");

  a_write_store: assert property (wr_commit |=> mem[$past(waddr)] == $past(next_nib))
    else $error("Written nibble not stored.");

  a_ignore_unknown: assert property (cmd_fire && !cmd_known |=> cfg == $past(cfg))
    else $error("Unknown command changed configuration.");

  a_irq_hold: assert property (wdt_flag && cfg.irq_en && cfg.wdt_out_en
    && !cfg.tb_route |=> !irq_n && !irq_oe_n)
    else $error("Interrupt released during watchdog time-out.");

  a_pitch_low: assert property (cmd_fire && cmd_hi[3:1] == lcdc_pkg::U3_LOW
    |=> cfg.buzzer_low)
    else $error("Low pitch not selected.");

endmodule : lcdc_decoder

`default_nettype wire

// file: rtl/lcdc_pkg.sv
// Constants, types and reset values shared by the LCD driver command decoder.
// Operation
// - Read: id 110, six address bits, D0 first
// - Write: id 101, address, four data bits stored
// - Read-modify-write reads nibble then rewrites same address
// - System disable stops oscillator and bias generator
// - System enable starts oscillator, bias unchanged
// - Bias generator off/on commands, off by default
// - Time base output disable and enable commands
// - Watchdog flag output disable and enable commands
// - Buzzer on/off; pitch high or low select
// - Time base clear zeroes the time base counter
// - Watchdog clear clears watchdog and time base
// - Clock source: crystal, internal RC, external
// - Field ab selects two, three, four commons
// - Three low bits set rate 2^n Hz
// - Watchdog flag after four selected clock periods
// - Normal mode default; test mode never issued
// - Reset defaults for every configuration field
// - Don't-care bits ignored; six address, four data
// - Successive commands need no repeated identifier
// - Deselect resets the current operation mode
// - Watchdog interrupt holds until clear or disable
// - Time base enable routes time base to interrupt
`default_nettype none

package lcdc_pkg;

  localparam int CLK_HZ = 20_000_000;
  localparam int TB_STEP_HZ = 256;
  localparam int TB_STEP_CYCLES = CLK_HZ / TB_STEP_HZ;
  localparam int RAM_DEPTH = 32;
  localparam int TB_STAGES = 8;

  // Stable pin levels in the order {data, read clock, write clock, select}.
  localparam logic [3:0] PIN_IDLE = 4'hF;

  localparam logic [2:0] ID_READ = 3'h6;
  localparam logic [2:0] ID_WRITE = 3'h5;
  localparam logic [2:0] ID_CMD = 3'h4;
  localparam logic [3:0] ID_LAST = 4'h2;
  localparam logic [3:0] ADDR_LAST = 4'h5;
  localparam logic [3:0] CMD_LAST = 4'h8;
  localparam logic [1:0] NIB_LAST = 2'h3;
  localparam logic [1:0] WDT_LAST = 2'h3;

  // Upper and lower nibble codes of the meaningful command bits.
  localparam logic [3:0] GRP_SYS = 4'h0;
  localparam logic [3:0] GRP_SRC = 4'h1;
  localparam logic [3:0] GRP_BIAS = 4'h2;
  localparam logic [3:0] GRP_MODE = 4'hE;
  localparam logic [2:0] U3_HIGH = 3'h2;
  localparam logic [2:0] U3_LOW = 3'h3;
  localparam logic [2:0] U3_IRQ = 3'h4;
  localparam logic [2:0] U3_RATE = 3'h5;
  localparam logic [3:0] SYSTEM_DISABLE_CMD = 4'h0;
  localparam logic [3:0] SYSTEM_ENABLE_CMD = 4'h1;
  localparam logic [3:0] LCD_OFF = 4'h2;
  localparam logic [3:0] LCD_ON = 4'h3;
  localparam logic [3:0] TB_DIS = 4'h4;
  localparam logic [3:0] WATCHDOG_OUTPUT_DISABLE_CMD = 4'h5;
  localparam logic [3:0] TB_EN = 4'h6;
  localparam logic [3:0] WATCHDOG_OUTPUT_ENABLE_CMD = 4'h7;
  localparam logic [3:0] TONE_OFF = 4'h8;
  localparam logic [3:0] TONE_ON = 4'h9;
  localparam logic [1:0] CLEAR_PAIR = 2'h3;
  localparam logic [1:0] COMMONS_BAD = 2'h3;
  localparam logic [3:0] MODE_TEST = 4'h0;
  localparam logic [3:0] MODE_NORMAL = 4'h3;

  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_RC = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [1:0] SRC_NONE = 2'h0;

  typedef enum logic [1:0] {
    ST_ID = 2'h0,
    ST_ADDR = 2'h1,
    ST_DATA = 2'h3,
    ST_CMD = 2'h2
  } lcdc_state_type;

  typedef struct packed {
    logic osc_on;
    logic bias_on;
    logic tb_out_en;
    logic wdt_out_en;
    logic tb_route;
    logic buzzer_on;
    logic buzzer_low;
    logic [1:0] clk_src;
    logic third_bias;
    logic [1:0] commons;
    logic [2:0] rate;
    logic irq_en;
    logic test_mode;
  } lcdc_cfg_type;

  localparam lcdc_cfg_type CFG_RESET = '{
    osc_on: 1'h0,
    bias_on: 1'h0,
    tb_out_en: 1'h0,
    wdt_out_en: 1'h0,
    tb_route: 1'h0,
    buzzer_on: 1'h0,
    buzzer_low: 1'h0,
    clk_src: 2'h2,
    third_bias: 1'h0,
    commons: 2'h0,
    rate: 3'h7,
    irq_en: 1'h0,
    test_mode: 1'h0
  };

endpackage : lcdc_pkg

`default_nettype wire

// file: tb/lcdc_decoder_tb_top.sv
// Self-checking bench for the LCD driver command decoder and its host model.
`timescale 1ns/1ps
`default_nettype none

module lcdc_decoder_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic host_bit;
  logic host_drive;
  logic data_pin;
  logic last_lvl = 1'b0;
  logic data_out;
  logic data_oe_n;
  logic irq_n;
  logic irq_oe_n;
  logic nib_valid;
  logic [3:0] nib;
  logic chk_cfg = 1'b0;
  logic chk_irq = 1'b0;
  logic [3:0] d;
  lcdc_pkg::lcdc_cfg_type cfg;
  lcdc_pkg::lcdc_cfg_type exp_cfg;
  lcdc_pkg::lcdc_cfg_type q_cfg[$];
  logic [1:0] q_irq[$];
  logic [3:0] q_nib[$];
  logic [3:0] mem[32];
  int num_errors = 0;
  int n_tests = 0;

  always #25 clk = ~clk;

  // The data line has no pull; a released line toggles so a stale level cannot pass.
  assign data_pin = host_drive ? host_bit : (!data_oe_n ? data_out : !last_lvl);
  always @(posedge clk) last_lvl <= data_pin;

  lcdc_decoder #(.TICK_CYCLES(4), .RAM_DEPTH(32)) lcdc_decoder_i (
    .clk(clk), .rst(rst), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .data_in(data_pin),
    .data_out(data_out), .data_oe_n(data_oe_n), .irq_n(irq_n), .irq_oe_n(irq_oe_n),
    .cfg(cfg)
  );

  lcdc_host lcdc_host_i (
    .clk(clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .bit_out(host_bit),
    .drive(host_drive), .pin(data_pin), .nib_valid(nib_valid), .nib(nib)
  );

  task automatic report(input logic bad, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (bad)
    begin
      num_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : report

  task automatic cmp_cfg(input lcdc_pkg::lcdc_cfg_type e, input lcdc_pkg::lcdc_cfg_type g);
    report(e !== g, 32'(e), 32'(g));
  endtask : cmp_cfg

  task automatic cmp_irq(input logic [1:0] e, input logic [1:0] g);
    report(e !== g, 32'(e), 32'(g));
  endtask : cmp_irq

  task automatic cmp_nib(input logic [3:0] e, input logic [3:0] g);
    report(e !== g, 32'(e), 32'(g));
  endtask : cmp_nib

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic end_test(input string s);
    $display("test %s finished, mismatches so far %0d", s, num_errors);
  endtask : end_test

  always @(posedge clk)
  begin
    if (chk_cfg === 1'b1)
      cmp_cfg(q_cfg.pop_front(), cfg);
    if (chk_irq === 1'b1)
      cmp_irq(q_irq.pop_front(), {irq_n, irq_oe_n});
    if (nib_valid === 1'b1)
      cmp_nib(q_nib.pop_front(), nib);
  end

  task automatic expect_cfg();
    q_cfg.push_back(exp_cfg);
    chk_cfg <= 1'b1;
    @(posedge clk);
    chk_cfg <= 1'b0;
  endtask : expect_cfg

  task automatic expect_irq(input logic [1:0] v);
    q_irq.push_back(v);
    chk_irq <= 1'b1;
    @(posedge clk);
    chk_irq <= 1'b0;
  endtask : expect_irq

  // Reference for the configuration that a command word leaves behind.
  task automatic model(input logic [7:0] m);
    if (m[7:4] == 4'h0)
      case (m[3:0])
        4'h0: {exp_cfg.osc_on, exp_cfg.bias_on} = 2'h0;
        4'h1: exp_cfg.osc_on = 1'b1;
        4'h2: exp_cfg.bias_on = 1'b0;
        4'h3: exp_cfg.bias_on = 1'b1;
        4'h4: exp_cfg.tb_out_en = 1'b0;
        4'h5: exp_cfg.wdt_out_en = 1'b0;
        4'h6: {exp_cfg.tb_out_en, exp_cfg.tb_route} = 2'h3;
        4'h7: {exp_cfg.wdt_out_en, exp_cfg.tb_route} = 2'h2;
        4'h8: exp_cfg.buzzer_on = 1'b0;
        4'h9: exp_cfg.buzzer_on = 1'b1;
        default: exp_cfg.osc_on = exp_cfg.osc_on;
      endcase
    else if (m[7:4] == 4'h1 && m[3:2] != 2'h0)
      exp_cfg.clk_src = m[3:2];
    else if (m[7:4] == 4'h2 && m[3:2] != 2'h3)
      {exp_cfg.commons, exp_cfg.third_bias} = {m[3:2], m[0]};
    else if (m[7:6] == 2'h1)
      exp_cfg.buzzer_low = m[5];
    else if (m[7:5] == 3'h4)
      exp_cfg.irq_en = m[3];
    else if (m[7:5] == 3'h5)
      exp_cfg.rate = m[2:0];
    else if (m == 8'hE3)
      exp_cfg.test_mode = 1'b0;
  endtask : model

  // The trailing bit is random because the decoder must ignore it.
  task automatic cmd(input logic [7:0] m);
    lcdc_host_i.send(16'({m, 1'($urandom)}), 9);
    model(m);
    repeat (8) @(posedge clk);
    expect_cfg();
  endtask : cmd

  task automatic open_cmd();
    lcdc_host_i.select(1'b1);
    lcdc_host_i.send(16'h0004, 3);
  endtask : open_cmd

  // Addresses wrap in six bits and the top bit is ignored by the 32-entry memory.
  task automatic wr_frame(input logic [5:0] a, input int n);
    lcdc_host_i.select(1'b1);
    lcdc_host_i.send(16'({3'h5, a}), 9);
    for (int k = 0; k < n; k++)
    begin
      d = 4'($urandom);
      lcdc_host_i.send(16'({d[0], d[1], d[2], d[3]}), 4);
      mem[5'(a + 6'(k))] = d;
    end
    lcdc_host_i.select(1'b0);
  endtask : wr_frame

  task automatic rd_frame(input logic [5:0] a, input int n);
    lcdc_host_i.select(1'b1);
    lcdc_host_i.send(16'({3'h6, a}), 9);
    for (int k = 0; k < n; k++)
    begin
      q_nib.push_back(mem[5'(a + 6'(k))]);
      lcdc_host_i.fetch();
    end
    lcdc_host_i.select(1'b0);
  endtask : rd_frame

  initial
  begin
    void'($urandom(64081));
    exp_cfg = '0;
    exp_cfg.clk_src = lcdc_pkg::SRC_RC;
    exp_cfg.rate = 3'h7;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    expect_cfg();
    expect_irq(2'h3);
    end_test("reset");
    open_cmd();
    // The test-mode code is never sent by a host.
    for (int i = 0; i < 256; i++)
      if (i != 8'hE0) cmd(8'(i));
    for (int i = 0; i < 40; i++)
      if (i != 8'hE0) cmd(8'($urandom_range(8'hDF)));
    lcdc_host_i.select(1'b0);
    end_test("commands");
    open_cmd();
    cmd(8'h03);
    lcdc_host_i.send(16'h0000, 5);
    lcdc_host_i.select(1'b0);
    lcdc_host_i.select(1'b1);
    lcdc_host_i.send(16'h0004, 9);
    lcdc_host_i.select(1'b0);
    expect_cfg();
    end_test("deselect");
    wr_frame(6'h3E, 3);
    rd_frame(6'h1E, 3);
    wr_frame(6'h05, 6);
    lcdc_host_i.select(1'b1);
    lcdc_host_i.send(16'({3'h5, 6'h07}), 9);
    for (int k = 7; k < 9; k++)
    begin
      q_nib.push_back(mem[k]);
      lcdc_host_i.fetch();
      d = 4'($urandom);
      lcdc_host_i.send(16'({d[0], d[1], d[2], d[3]}), 4);
      mem[k] = d;
    end
    lcdc_host_i.select(1'b0);
    rd_frame(6'h05, 6);
    end_test("memory");
    open_cmd();
    cmd(8'h01);
    cmd(8'hA0);
    cmd(8'h07);
    cmd(8'h88);
    cmd(8'h0E);
    lcdc_host_i.select(1'b0);
    // The pair is {level, enable}: a driven pin shows 2'h2 when quiet and 2'h0 when asserted.
    repeat (3800) @(posedge clk);
    expect_irq(2'h2);
    repeat (600) @(posedge clk);
    expect_irq(2'h0);
    repeat (500) @(posedge clk);
    expect_irq(2'h0);
    open_cmd();
    cmd(8'h0E);
    expect_irq(2'h2);
    lcdc_host_i.select(1'b0);
    end_test("watchdog");
    repeat (4) @(posedge clk);
    finish_test();
  end

  // The tests need about 31000 cycles; the limit leaves ample margin.
  initial
  begin
    repeat (90000) @(posedge clk);
    num_errors++;
    finish_test();
  end
endmodule : lcdc_decoder_tb_top

`default_nettype wire

// file: tb/lcdc_host.sv
// Host controller model that drives the three-wire serial port of the decoder.
`timescale 1ns/1ps
`default_nettype none

module lcdc_host (
  input wire logic clk,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic bit_out,
  output logic drive,
  input wire logic pin,
  output logic nib_valid,
  output logic [3:0] nib
);
  initial
  begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    bit_out = 1'b0;
    drive = 1'b0;
    nib_valid = 1'b0;
    nib = 4'h0;
  end

  // Dropping select also resets the operation mode, so a new frame needs a new id.
  task automatic select(input logic on);
    @(posedge clk);
    cs_n <= !on;
    repeat (8) @(posedge clk);
  endtask : select

  // Bits leave most significant first on a 400 ns link clock that idles high.
  task automatic send(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge clk);
      wr_n <= 1'b0;
      bit_out <= v[i];
      drive <= 1'b1;
      repeat (4) @(posedge clk);
      wr_n <= 1'b1;
      repeat (3) @(posedge clk);
    end
    @(posedge clk);
    drive <= 1'b0;
  endtask : send

  // Nibble comes back lowest bit first; sampled late because the answer lags the fall.
  task automatic fetch();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      rd_n <= 1'b0;
      repeat (4) @(posedge clk);
      rd_n <= 1'b1;
      repeat (4) @(posedge clk);
      nib[i] <= pin;
    end
    @(posedge clk);
    nib_valid <= 1'b1;
    @(posedge clk);
    nib_valid <= 1'b0;
  endtask : fetch
endmodule : lcdc_host

`default_nettype wire
